// *** rtl/lvd_pkg.sv ***
// shared constants and types of the supply voltage monitor
package lvd_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_IRQ_CTRL = 2'h1;
    localparam logic [1:0] ADDR_PIE_TWO = 2'h2;
    localparam logic [1:0] ADDR_PIR_TWO = 2'h3;
    localparam int BIT_STABLE = 5;
    localparam int BIT_ENABLE = 4;
    localparam int BIT_GLOBAL_IE = 7;
    localparam int BIT_PERIPH_IE = 6;
    localparam int BIT_LV = 2;
    localparam logic [2:0] TRIP_RESET = 3'h4;
    localparam logic [7:0] PIE_TWO_MASK = 8'hf5;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic tripBelow;
        logic refStable;
    } analog_in_t;
endpackage

// *** rtl/sync_two_ff.sv ***
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module sync_two_ff (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.first = din;
        next_state.second = state.first;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign dout = state.second;
endmodule // sync_two_ff

// *** rtl/low_voltage_detect_ctrl.sv ***
// control, flag and interrupt logic of the supply voltage monitor
`timescale 1ns/1ps
// Function
// - enable bit powers detector and reference up; clear powers both down.
// - three-bit trip level selects threshold; reset value 100.
// - flag sets on falling crossing only, not while staying low.
// - flag stays set until software writes zero.
// - interrupt when flag, its enable, peripheral and global enable all set.
// - software writing one to flag acts like real detection.
// - bit 5 reads reference stable status, valid with fast oscillator.
// - in sleep, flag with both enables wakes the device.
// - with global enable too, service routine follows after wake.
// - control bits 7:6 and 3 ignore writes, read zero.
module low_voltage_detect_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire lvd_pkg::bus_req_t busReq,
    output logic [7:0] rdata,
    input wire lvd_pkg::analog_in_t analogIn,
    input wire logic fastOscRunning,
    output logic monitorPowerEnable,
    output logic [2:0] tripLevelSelect,
    output logic irqRequest,
    output logic wakeRequest
);
    typedef struct packed {
        logic monitorPowerEnable;
        logic [2:0] tripLevelSelect;
        logic [7:0] interruptControl;
        logic [7:0] peripheralIrqEnableTwo;
        logic [7:0] peripheralIrqFlagsTwo;
        logic belowPrev;
        logic [7:0] rdata;
        logic irqRequest;
        logic wakeRequest;
    } state_t;

    state_t state;
    state_t next_state;
    logic belowSync;
    logic stableSync;
    logic fallEvent;
    logic lvFlag;
    logic lvIe;
    logic [7:0] controlRead;

    sync_two_ff u_syncBelow (
        .clk(clk),
        .reset(reset),
        .din(analogIn.tripBelow),
        .dout(belowSync)
    );
    sync_two_ff u_syncStable (
        .clk(clk),
        .reset(reset),
        .din(analogIn.refStable),
        .dout(stableSync)
    );

    assign fallEvent = state.monitorPowerEnable && belowSync && !state.belowPrev;

    always_comb begin
        controlRead = lvd_pkg::ZERO_BYTE;
        controlRead[lvd_pkg::BIT_STABLE] = stableSync && fastOscRunning
            && state.monitorPowerEnable;
        controlRead[lvd_pkg::BIT_ENABLE] = state.monitorPowerEnable;
        controlRead[2:0] = state.tripLevelSelect;
    end

    always_comb begin
        next_state = state;
        next_state.belowPrev = belowSync && state.monitorPowerEnable;
        if (busReq.wr) begin
            unique case (busReq.addr[lvd_pkg::ADDR_W-1:0])
                lvd_pkg::ADDR_CONTROL: begin
                    next_state.monitorPowerEnable = busReq.wdata[lvd_pkg::BIT_ENABLE];
                    next_state.tripLevelSelect = busReq.wdata[2:0];
                end
                lvd_pkg::ADDR_IRQ_CTRL: begin
                    next_state.interruptControl = busReq.wdata;
                end
                lvd_pkg::ADDR_PIE_TWO: begin
                    next_state.peripheralIrqEnableTwo = busReq.wdata & lvd_pkg::PIE_TWO_MASK;
                end
                lvd_pkg::ADDR_PIR_TWO: begin
                    next_state.peripheralIrqFlagsTwo = busReq.wdata & lvd_pkg::PIE_TWO_MASK;
                end
            endcase
        end
        if (fallEvent) begin
            next_state.peripheralIrqFlagsTwo[lvd_pkg::BIT_LV] = 1'b1;
        end
        next_state.rdata = lvd_pkg::ZERO_BYTE;
        if (busReq.rd) begin
            unique case (busReq.addr[lvd_pkg::ADDR_W-1:0])
                lvd_pkg::ADDR_CONTROL: next_state.rdata = controlRead;
                lvd_pkg::ADDR_IRQ_CTRL: next_state.rdata = state.interruptControl;
                lvd_pkg::ADDR_PIE_TWO: next_state.rdata = state.peripheralIrqEnableTwo;
                lvd_pkg::ADDR_PIR_TWO: next_state.rdata = state.peripheralIrqFlagsTwo;
            endcase
        end
        next_state.irqRequest = next_state.peripheralIrqFlagsTwo[lvd_pkg::BIT_LV]
            && next_state.peripheralIrqEnableTwo[lvd_pkg::BIT_LV]
            && next_state.interruptControl[lvd_pkg::BIT_PERIPH_IE]
            && next_state.interruptControl[lvd_pkg::BIT_GLOBAL_IE];
        next_state.wakeRequest = next_state.peripheralIrqFlagsTwo[lvd_pkg::BIT_LV]
            && next_state.peripheralIrqEnableTwo[lvd_pkg::BIT_LV]
            && next_state.interruptControl[lvd_pkg::BIT_PERIPH_IE];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.tripLevelSelect <= lvd_pkg::TRIP_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign lvFlag = state.peripheralIrqFlagsTwo[lvd_pkg::BIT_LV];
    assign lvIe = state.peripheralIrqEnableTwo[lvd_pkg::BIT_LV];
    assign rdata = state.rdata;
    assign monitorPowerEnable = state.monitorPowerEnable;
    assign tripLevelSelect = state.tripLevelSelect;
    assign irqRequest = state.irqRequest;
    assign wakeRequest = state.wakeRequest;

    // decoded strobes for the checks below
    logic [lvd_pkg::ADDR_W-1:0] regIndex;
    logic wrControl;
    logic wrIrqCtrl;
    logic wrPieTwo;
    logic wrPirTwo;
    logic rdControl;
    logic rdIrqCtrl;
    logic rdPieTwo;
    logic rdPirTwo;
    assign regIndex = busReq.addr[lvd_pkg::ADDR_W-1:0];
    assign wrControl = busReq.wr && regIndex == lvd_pkg::ADDR_CONTROL;
    assign wrIrqCtrl = busReq.wr && regIndex == lvd_pkg::ADDR_IRQ_CTRL;
    assign wrPieTwo = busReq.wr && regIndex == lvd_pkg::ADDR_PIE_TWO;
    assign wrPirTwo = busReq.wr && regIndex == lvd_pkg::ADDR_PIR_TWO;
    assign rdControl = busReq.rd && regIndex == lvd_pkg::ADDR_CONTROL;
    assign rdIrqCtrl = busReq.rd && regIndex == lvd_pkg::ADDR_IRQ_CTRL;
    assign rdPieTwo = busReq.rd && regIndex == lvd_pkg::ADDR_PIE_TWO;
    assign rdPirTwo = busReq.rd && regIndex == lvd_pkg::ADDR_PIR_TWO;

    AST_FALL_SETS_FLAG: assert property (@(posedge clk) disable iff (reset)
        fallEvent |=> lvFlag)
        else $error("fall did not set flag");

    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (reset)
        lvFlag && !wrPirTwo |=> lvFlag)
        else $error("flag cleared by hardware");

    AST_IRQ_GATE: assert property (@(posedge clk) disable iff (reset)
        irqRequest == (lvFlag && lvIe && state.interruptControl[lvd_pkg::BIT_PERIPH_IE]
        && state.interruptControl[lvd_pkg::BIT_GLOBAL_IE])) else $error("irq mismatch");

    AST_WAKE_GATE: assert property (@(posedge clk) disable iff (reset)
        wakeRequest == (lvFlag && lvIe && state.interruptControl[lvd_pkg::BIT_PERIPH_IE]))
        else $error("wake mismatch");

    AST_SW_SET: assert property (@(posedge clk) disable iff (reset)
        wrPirTwo && busReq.wdata[lvd_pkg::BIT_LV] |=> lvFlag)
        else $error("software set lost");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
        rdControl |=> rdata[7:6] == 2'b00 && !rdata[3])
        else $error("reserved bit set");

    AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (reset)
        wrControl |=> monitorPowerEnable == $past(busReq.wdata[lvd_pkg::BIT_ENABLE]))
        else $error("enable not written");

    AST_LEVEL_WRITE: assert property (@(posedge clk) disable iff (reset)
        wrControl |=> tripLevelSelect == $past(busReq.wdata[2:0]))
        else $error("level not written");

    AST_NO_LEVEL_SET: assert property (@(posedge clk) disable iff (reset)
        !lvFlag && !fallEvent && !busReq.wr |=> !lvFlag)
        else $error("flag set by level");

    AST_OFF_NO_EVENT: assert property (@(posedge clk) disable iff (reset)
        !state.monitorPowerEnable |-> !fallEvent)
        else $error("event while disabled");

    AST_OFF_NOT_STABLE: assert property (@(posedge clk) disable iff (reset)
        rdControl && !monitorPowerEnable |=> !rdata[lvd_pkg::BIT_STABLE])
        else $error("stable while disabled");

    AST_STABLE_NEEDS_OSC: assert property (@(posedge clk) disable iff (reset)
        rdControl && !fastOscRunning |=> !rdata[lvd_pkg::BIT_STABLE])
        else $error("stable without oscillator");

    AST_STABLE_READ: assert property (@(posedge clk) disable iff (reset)
        rdControl && monitorPowerEnable && fastOscRunning
        |=> rdata[lvd_pkg::BIT_STABLE] == $past(stableSync)) else $error("stable misread");

    AST_CONTROL_READ: assert property (@(posedge clk) disable iff (reset)
        rdControl |=> rdata[lvd_pkg::BIT_ENABLE] == $past(monitorPowerEnable)
        && rdata[2:0] == $past(tripLevelSelect)) else $error("control misread");

    // read data one cycle only
    AST_READ_IDLE_ZERO: assert property (@(posedge clk) disable iff (reset)
        !busReq.rd |=> rdata == lvd_pkg::ZERO_BYTE)
        else $error("read data without read");

    AST_FLAG_READ: assert property (@(posedge clk) disable iff (reset)
        rdPirTwo |=> rdata == $past(state.peripheralIrqFlagsTwo))
        else $error("flags misread");

    AST_IE_READ: assert property (@(posedge clk) disable iff (reset)
        rdPieTwo |=> rdata == $past(state.peripheralIrqEnableTwo))
        else $error("enables misread");

    AST_IRQ_CTRL_READ: assert property (@(posedge clk) disable iff (reset)
        rdIrqCtrl |=> rdata == $past(state.interruptControl))
        else $error("interrupt control misread");

    // unimplemented flag bits stay zero
    AST_FLAG_BITS_ZERO: assert property (@(posedge clk) disable iff (reset)
        (state.peripheralIrqFlagsTwo & ~lvd_pkg::PIE_TWO_MASK) == lvd_pkg::ZERO_BYTE)
        else $error("unimplemented flag bit set");

    // unimplemented enable bits stay zero
    AST_IE_BITS_ZERO: assert property (@(posedge clk) disable iff (reset)
        (state.peripheralIrqEnableTwo & ~lvd_pkg::PIE_TWO_MASK) == lvd_pkg::ZERO_BYTE)
        else $error("unimplemented enable bit set");

    AST_SW_CLEAR: assert property (@(posedge clk) disable iff (reset)
        wrPirTwo && !busReq.wdata[lvd_pkg::BIT_LV] && !fallEvent |=> !lvFlag)
        else $error("software clear lost");

    AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
        wrPirTwo && fallEvent |=> lvFlag)
        else $error("event lost to clear");

    AST_EVENT_ON_DROP: assert property (@(posedge clk) disable iff (reset)
        state.monitorPowerEnable && $past(state.monitorPowerEnable) && $rose(belowSync)
        |-> fallEvent) else $error("fall not detected");

    AST_NO_EVENT_STEADY: assert property (@(posedge clk) disable iff (reset)
        $past(belowSync) && belowSync && $past(state.monitorPowerEnable) |-> !fallEvent)
        else $error("event on steady level");

    AST_IRQ_NEEDS_GLOBAL: assert property (@(posedge clk) disable iff (reset)
        !state.interruptControl[lvd_pkg::BIT_GLOBAL_IE] |-> !irqRequest)
        else $error("irq without global enable");

    AST_IRQ_IMPLIES_WAKE: assert property (@(posedge clk) disable iff (reset)
        irqRequest |-> wakeRequest)
        else $error("irq without wake");

    AST_CONTROL_HOLD: assert property (@(posedge clk) disable iff (reset)
        !wrControl |=> $stable(monitorPowerEnable) && $stable(tripLevelSelect))
        else $error("control changed without write");

    AST_IE_WRITE: assert property (@(posedge clk) disable iff (reset)
        wrPieTwo |=> lvIe == $past(busReq.wdata[lvd_pkg::BIT_LV]))
        else $error("interrupt enable not written");

    AST_IRQ_CTRL_WRITE: assert property (@(posedge clk) disable iff (reset)
        wrIrqCtrl |=> state.interruptControl == $past(busReq.wdata))
        else $error("interrupt control not written");

    AST_SYNC_BELOW: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) && !$past(reset, 2) |-> belowSync == $past(analogIn.tripBelow, 2))
        else $error("comparator sync delay wrong");

    AST_SYNC_STABLE: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) && !$past(reset, 2) |-> stableSync == $past(analogIn.refStable, 2))
        else $error("reference sync delay wrong");
endmodule // low_voltage_detect_ctrl

// *** dv/supply_comparator_model.sv ***
// behavioural supply comparator and reference beside the voltage monitor
`timescale 1ns/1ps
module supply_comparator_model (
    input wire logic clk,
    input wire logic powerEnable,
    input wire logic [2:0] levelSelect,
    input wire logic [15:0] supplyMv,
    output lvd_pkg::analog_in_t analogOut
);
    logic [15:0] tripMv;
    logic [4:0] settle = 5'h00;
    // threshold per level, reserved code as zero
    always_comb begin
        case (levelSelect)
            3'h1: tripMv = 16'h07d0;
            3'h2: tripMv = 16'h0834;
            3'h3: tripMv = 16'h0898;
            3'h4: tripMv = 16'h08fc;
            3'h5: tripMv = 16'h0fa0;
            3'h6: tripMv = 16'h1068;
            3'h7: tripMv = 16'h1194;
            default: tripMv = 16'h0000;
        endcase
    end
    always_ff @(posedge clk) begin
        settle <= !powerEnable ? 5'h00 : (settle == 5'h1f ? settle : settle + 5'h01);
    end
    assign analogOut = {powerEnable && (supplyMv < tripMv), settle == 5'h1f};
endmodule // supply_comparator_model

// *** dv/low_voltage_detect_ctrl_tb.sv ***
// self-checking bench of the supply voltage monitor control
`timescale 1ns/1ps
module low_voltage_detect_ctrl_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    lvd_pkg::bus_req_t busReq = '0;
    lvd_pkg::analog_in_t analogIn;
    logic fastOscRunning = 1'b1;
    logic [15:0] supplyMv = 16'h1388;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [2:0] tripLevelSelect;
    logic monitorPowerEnable, irqRequest, wakeRequest;
    int n_errors = 0, n_tests = 0, cycles = 0;
    always #10 clk = ~clk;
    low_voltage_detect_ctrl dut_u (.clk(clk), .reset(reset), .busReq(busReq), .rdata(rdata),
        .analogIn(analogIn), .fastOscRunning(fastOscRunning),
        .monitorPowerEnable(monitorPowerEnable), .tripLevelSelect(tripLevelSelect),
        .irqRequest(irqRequest), .wakeRequest(wakeRequest));
    supply_comparator_model model_u (.clk(clk), .powerEnable(monitorPowerEnable),
        .levelSelect(tripLevelSelect), .supplyMv(supplyMv), .analogOut(analogIn));
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) busReq <= {a, d, 2'b10};
        @(posedge clk) busReq.wr <= 1'b0;
        #1;
    endtask
    task automatic rdReg(input logic [7:0] a);
        @(posedge clk) busReq <= {a, 8'h00, 2'b01};
        @(posedge clk) busReq.rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic checkIrq(input logic [1:0] exp);
        repeat (2) @(posedge clk);
        #1 check({6'h00, irqRequest, wakeRequest}, {6'h00, exp});
    endtask
    task automatic levels;
        rdReg(8'h00);
        check(got, 8'h04);
        for (int i = 7; i >= 0; i--) begin
            wr(8'h00, 8'hc8 | 8'(i));
            check({5'h00, tripLevelSelect}, 8'(i));
        end
        rdReg(8'h00);
        check(got, 8'h00);
        check({7'h00, monitorPowerEnable}, 8'h00);
    endtask
    task automatic setup;
        wr(8'h00, 8'h10);
        check({7'h00, monitorPowerEnable}, 8'h01);
        wr(8'h00, 8'h17);
        rdReg(8'h00);
        check(got, 8'h17);
        for (int i = 0; i < 60 && got[5] !== 1'b1; i++) rdReg(8'h00);
        check(got, 8'h37);
        @(posedge clk) fastOscRunning <= 1'b0;
        rdReg(8'h00);
        check(got, 8'h17);
        @(posedge clk) fastOscRunning <= 1'b1;
        wr(8'h03, 8'h00);
    endtask
    task automatic supplyTo(input logic [15:0] mv);
        @(posedge clk) supplyMv <= mv;
        repeat (8) @(posedge clk);
        rdReg(8'h03);
    endtask
    task automatic detect;
        supplyTo(16'h1000);
        check(got, 8'h04);
        checkIrq(2'b00);
        wr(8'h03, 8'h00);
        supplyTo(16'h1000);
        check(got, 8'h00);
        supplyTo(16'h1388);
        supplyTo(16'h1000);
        supplyTo(16'h1388);
        check(got, 8'h04);
        wr(8'h03, 8'h00);
    endtask
    task automatic irq;
        wr(8'h02, 8'h04);
        wr(8'h01, 8'hc0);
        checkIrq(2'b00);
        wr(8'h03, 8'h04);
        checkIrq(2'b11);
        wr(8'h01, 8'h40);
        checkIrq(2'b01);
        wr(8'h01, 8'h80);
        checkIrq(2'b00);
        wr(8'h02, 8'h00);
        checkIrq(2'b00);
        wr(8'h03, 8'h00);
    endtask
    task automatic resetMid;
        wr(8'h03, 8'h04);
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1 check({4'h0, monitorPowerEnable, tripLevelSelect}, 8'h04);
        check({6'h00, irqRequest, wakeRequest}, 8'h00);
        rdReg(8'h00);
        check(got, 8'h04);
        rdReg(8'h03);
        check(got, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        levels();
        setup();
        detect();
        irq();
        resetMid();
        final_report();
    end
endmodule // low_voltage_detect_ctrl_tb
